// [verilog/pll_ref_and_phase_detect.sv]
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pll_ref_regs.svh"
module pll_ref_and_phase_detect
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_input,
    input  wire logic        divided_reference_pulse,
    input  wire logic        divided_vco_pulse,
    input  wire logic        vco_input,
    input  wire logic        modulus_select,
    output logic             divided_osc_output,
    output logic             osc_run,
    output logic             ref_count_enable,
    output logic             charge_pump_output,
    output logic             charge_pump_oe,
    output logic      [6:0]  charge_pump_current,
    output logic             phi_r,
    output logic             phi_v,
    output logic             lock_indicator,
    output logic             prescaler_output
);
    pll_ref_pkg::top_state_t s_r;
    pll_ref_pkg::top_state_t s_nxt;
    prescale_if              presc();

    logic                    setup;
    logic                    access;
    logic                    osc_rise;
    logic                    ref_rise;
    logic                    vco_rise;
    logic [3:0]              half;
    logic                    divide_mode;
    logic                    sense_invert;
    logic                    detector_select;
    logic                    lock_enable;
    logic                    power_save;
    logic [1:0]              cur_code;
    logic                    ref_flag;
    logic                    vco_flag;
    logic                    vco_leads;
    logic                    vco_lags;
    logic                    mapped;

    assign presc.vco_in         = vco_input;
    assign presc.modulus_select = modulus_select;

    dual_modulus_prescaler u_presc
    (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (presc)
    );

    always_comb
    begin
        s_nxt = s_r;
        setup = psel & ~penable;
        access = psel & penable & s_r.pready;
        mapped = (paddr == `ADDR_REF_MODE) | (paddr == `ADDR_CONFIG)
               | (paddr == `ADDR_STATUS);

        // Register writes at the access edge
        if (access & pwrite & pstrb[0])
        begin
            if (paddr == `ADDR_REF_MODE)
            begin
                s_nxt.ref_mode = pwdata[`REF_MODE_W-1:0];
            end
            else if (paddr == `ADDR_CONFIG)
            begin
                s_nxt.cfg = pwdata[`CFG_W-1:0] & `CFG_WRITE_MASK;
            end
        end

        // Answer one cycle after setup
        s_nxt.pready = setup;
        s_nxt.pslverr = setup & ~mapped;
        s_nxt.prdata = 32'h0000_0000;
        if (setup & ~pwrite)
        begin
            case (paddr)
                `ADDR_REF_MODE:
                begin
                    s_nxt.prdata[`REF_MODE_W-1:0] = s_r.ref_mode;
                end
                `ADDR_CONFIG:
                begin
                    s_nxt.prdata[`CFG_W-1:0] = s_r.cfg;
                end
                `ADDR_STATUS:
                begin
                    s_nxt.prdata[0] = s_r.osc_run;
                    s_nxt.prdata[1] = s_r.ref_cnt_en;
                    s_nxt.prdata[2] = s_r.div_out;
                    s_nxt.prdata[3] = s_r.lock;
                    s_nxt.prdata[4] = s_r.cp_oe;
                    s_nxt.prdata[5] = s_r.cp_drive;
                    s_nxt.prdata[6] = s_r.phi_r;
                    s_nxt.prdata[7] = s_r.phi_v;
                    s_nxt.prdata[14:8] = s_r.cp_current;
                    s_nxt.prdata[16:15] = s_r.pfd;
                    s_nxt.prdata[17] = presc.prescale_out;
                end
                default:
                begin
                    s_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end

        sense_invert = s_nxt.cfg[`CFG_SENSE_INVERT];
        detector_select = s_nxt.cfg[`CFG_DETECTOR_SELECT];
        lock_enable = s_nxt.cfg[`CFG_LOCK_ENABLE];
        power_save = s_nxt.cfg[`CFG_POWER_SAVE];
        cur_code = {s_nxt.cfg[`CFG_CURRENT_HI], s_nxt.cfg[`CFG_CURRENT_LO]};

        // Oscillator and reference counter control
        s_nxt.osc_run = (s_nxt.ref_mode == `REF_MODE_XTAL_RUN);
        s_nxt.ref_cnt_en = (s_nxt.ref_mode != `REF_MODE_XTAL_OFF)
                         & ~power_save;

        // Reference output divider
        osc_rise = osc_input & ~s_r.osc_prev;
        s_nxt.osc_prev = osc_input;
        divide_mode = 1'b1;
        case (s_nxt.ref_mode)
            `REF_MODE_DIV2:
            begin
                half = `HALF_DIV2;
            end
            `REF_MODE_DIV4:
            begin
                half = `HALF_DIV4;
            end
            `REF_MODE_DIV8:
            begin
                half = `HALF_DIV8;
            end
            `REF_MODE_DIV16:
            begin
                half = `HALF_DIV16;
            end
            default:
            begin
                half = `HALF_DIV2;
                divide_mode = 1'b0;
            end
        endcase
        if (s_nxt.ref_mode == `REF_MODE_DIV1)
        begin
            s_nxt.div_cnt = 4'h0;
            s_nxt.div_out = osc_input;
        end
        else if (divide_mode)
        begin
            if (osc_rise)
            begin
                if (s_r.div_cnt >= half - 4'h1)
                begin
                    s_nxt.div_cnt = 4'h0;
                    s_nxt.div_out = ~s_r.div_out;
                end
                else
                begin
                    s_nxt.div_cnt = s_r.div_cnt + 4'h1;
                end
            end
        end
        else
        begin
            // Crystal modes and the disabled-output mode keep it low
            s_nxt.div_cnt = 4'h0;
            s_nxt.div_out = 1'b0;
        end

        // Phase frequency detector
        ref_rise = divided_reference_pulse & ~s_r.ref_prev;
        vco_rise = divided_vco_pulse & ~s_r.vco_prev;
        s_nxt.ref_prev = divided_reference_pulse;
        s_nxt.vco_prev = divided_vco_pulse;
        case (s_r.pfd)
            pll_ref_pkg::PFD_REF_AHEAD:
            begin
                if (vco_rise)
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_BOTH;
                end
            end
            pll_ref_pkg::PFD_VCO_AHEAD:
            begin
                if (ref_rise)
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_BOTH;
                end
            end
            pll_ref_pkg::PFD_IDLE,
            pll_ref_pkg::PFD_BOTH:
            begin
                // Both-low cycle is the narrow in-phase pulse
                if (ref_rise & vco_rise)
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_BOTH;
                end
                else if (ref_rise)
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_REF_AHEAD;
                end
                else if (vco_rise)
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_VCO_AHEAD;
                end
                else
                begin
                    s_nxt.pfd = pll_ref_pkg::PFD_IDLE;
                end
            end
            default:
            begin
                s_nxt.pfd = pll_ref_pkg::PFD_IDLE;
            end
        endcase
        if (power_save)
        begin
            s_nxt.pfd = pll_ref_pkg::PFD_IDLE;
        end
        ref_flag = (s_nxt.pfd == pll_ref_pkg::PFD_REF_AHEAD)
                 | (s_nxt.pfd == pll_ref_pkg::PFD_BOTH);
        vco_flag = (s_nxt.pfd == pll_ref_pkg::PFD_VCO_AHEAD)
                 | (s_nxt.pfd == pll_ref_pkg::PFD_BOTH);
        vco_leads = vco_flag & ~ref_flag;
        vco_lags = ref_flag & ~vco_flag;

        // Charge pump: drive 1 sources, drive 0 sinks
        s_nxt.cp_drive = sense_invert ? vco_leads : vco_lags;
        s_nxt.cp_oe = detector_select & ~power_save
                    & (vco_leads | vco_lags);

        // Pulse pair outputs, active low
        if (detector_select | power_save)
        begin
            s_nxt.phi_r = 1'b1;
            s_nxt.phi_v = 1'b1;
        end
        else
        begin
            s_nxt.phi_v = ~(sense_invert ? ref_flag : vco_flag);
            s_nxt.phi_r = ~(sense_invert ? vco_flag : ref_flag);
        end

        s_nxt.lock = lock_enable & s_nxt.phi_r & s_nxt.phi_v;

        // Pump current in percent of maximum
        if (s_nxt.cfg[`CFG_CURRENT_STEP])
        begin
            s_nxt.cp_current = `CUR_COARSE_STEP * (7'({5'h00, cur_code}) + 7'h01);
        end
        else
        begin
            s_nxt.cp_current = `CUR_FINE_BASE
                             + `CUR_FINE_STEP * 7'({5'h00, cur_code});
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.ref_mode <= `REF_MODE_RESET;
            s_r.cfg <= `CFG_RESET;
            s_r.phi_r <= 1'b1;
            s_r.phi_v <= 1'b1;
            s_r.ref_cnt_en <= 1'b1;
            s_r.cp_current <= `CUR_FINE_BASE;
            s_r.pfd <= pll_ref_pkg::PFD_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata              = s_r.prdata;
    assign pready              = s_r.pready;
    assign pslverr             = s_r.pslverr;
    assign divided_osc_output  = s_r.div_out;
    assign osc_run             = s_r.osc_run;
    assign ref_count_enable    = s_r.ref_cnt_en;
    assign charge_pump_output  = s_r.cp_drive;
    assign charge_pump_oe      = s_r.cp_oe;
    assign charge_pump_current = s_r.cp_current;
    assign phi_r               = s_r.phi_r;
    assign phi_v               = s_r.phi_v;
    assign lock_indicator      = s_r.lock;
    assign prescaler_output    = presc.prescale_out;
endmodule : pll_ref_and_phase_detect
`default_nettype wire

// [verilog/pll_ref_regs.svh]
// How it works
// - Mode 001 runs crystal, feeds reference counter
// - Crystal mode plus power save halts counter
// - Mode zero stops the crystal oscillator
// - Mode seven divides reference output by 16
// - Mode three passes reference one to one
// - Reset mode gives divide by eight
// - Mode two keeps input, disables output
// - Prescaler divides 65 low, 64 high
// - Normal sense: sink leading, source lagging
// - Inverted sense: source leading, sink lagging
// - Pump floats when deselected or power save
// - Pulse pair outputs follow lead, swap inverted
// - Pulse pair held high when off
// - Lock indicator ANDs pulse pair outputs
// - Lock indicator gated, low after reset
// - Three bits set pump current, both highs max
// - Select bit chooses pump or pulse pair
// - Sense bit swaps polarity, clears at reset
// - Lock enable clear forces indicator low
`ifndef PLL_REF_REGS_SVH
`define PLL_REF_REGS_SVH

`define ADDR_REF_MODE       12'h000
`define ADDR_CONFIG         12'h004
`define ADDR_STATUS         12'h008

`define REF_MODE_W          3
`define REF_MODE_XTAL_OFF   3'h0
`define REF_MODE_XTAL_RUN   3'h1
`define REF_MODE_OUT_OFF    3'h2
`define REF_MODE_DIV1       3'h3
`define REF_MODE_DIV2       3'h4
`define REF_MODE_DIV4       3'h5
`define REF_MODE_DIV8       3'h6
`define REF_MODE_DIV16      3'h7
`define REF_MODE_RESET      3'h6

`define HALF_DIV2           4'h1
`define HALF_DIV4           4'h2
`define HALF_DIV8           4'h4
`define HALF_DIV16          4'h8

`define CFG_W               8
`define CFG_RESET           8'h00
`define CFG_SENSE_INVERT    7
`define CFG_DETECTOR_SELECT 6
`define CFG_LOCK_ENABLE     5
`define CFG_POWER_SAVE      4
`define CFG_CURRENT_HI      3
`define CFG_CURRENT_LO      2
`define CFG_CURRENT_STEP    1
`define CFG_WRITE_MASK      8'hFE

`define CUR_FINE_BASE       7'h46
`define CUR_FINE_STEP       7'h0A
`define CUR_COARSE_STEP     7'h19

`define PRESC_MOD_HIGH      7'h40
`define PRESC_MOD_LOW       7'h41
`define PRESC_HALF          7'h20

`endif

// [verilog/pll_ref_pkg.sv]
`default_nettype none
package pll_ref_pkg;
`include "pll_ref_regs.svh"

    typedef enum logic [1:0] {
        PFD_IDLE,
        PFD_REF_AHEAD,
        PFD_VCO_AHEAD,
        PFD_BOTH
    } pfd_state_t;

    typedef struct packed {
        logic [`REF_MODE_W-1:0] ref_mode;
        logic [`CFG_W-1:0]      cfg;
        logic                   osc_prev;
        logic                   ref_prev;
        logic                   vco_prev;
        logic [3:0]             div_cnt;
        logic                   div_out;
        pfd_state_t             pfd;
        logic                   cp_drive;
        logic                   cp_oe;
        logic                   phi_r;
        logic                   phi_v;
        logic                   lock;
        logic                   osc_run;
        logic                   ref_cnt_en;
        logic [6:0]             cp_current;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } top_state_t;

    typedef struct packed {
        logic       vco_prev;
        logic       mod_low;
        logic [6:0] cnt;
        logic       out;
    } presc_state_t;

endpackage : pll_ref_pkg
`default_nettype wire

// [verilog/prescale_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
    logic vco_in;
    logic modulus_select;
    logic prescale_out;

    modport core
    (
        input  vco_in,
        input  modulus_select,
        output prescale_out
    );

    modport top
    (
        output vco_in,
        output modulus_select,
        input  prescale_out
    );
endinterface : prescale_if
`default_nettype wire

// [verilog/dual_modulus_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pll_ref_regs.svh"
module dual_modulus_prescaler
(
    input  wire logic pclk,
    input  wire logic presetn,
    prescale_if.core  link
);
    pll_ref_pkg::presc_state_t s_r;
    pll_ref_pkg::presc_state_t s_nxt;
    logic                      rise;
    logic [6:0]                last;

    always_comb
    begin
        s_nxt = s_r;
        rise = link.vco_in & ~s_r.vco_prev;
        s_nxt.vco_prev = link.vco_in;
        last = (s_r.mod_low ? `PRESC_MOD_LOW : `PRESC_MOD_HIGH) - 7'h01;
        if (rise)
        begin
            if (s_r.cnt == last)
            begin
                s_nxt.cnt = 7'h00;
                // Modulus taken only at wrap so a cycle is never cut
                s_nxt.mod_low = ~link.modulus_select;
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 7'h01;
            end
        end
        s_nxt.out = (s_nxt.cnt < `PRESC_HALF);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign link.prescale_out = s_r.out;
endmodule : dual_modulus_prescaler
`default_nettype wire

// [sim/pll_ref_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_ref_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        osc_input,
    input wire logic        divided_reference_pulse,
    input wire logic        divided_vco_pulse,
    input wire logic        divided_osc_output,
    input wire logic        osc_run,
    input wire logic        charge_pump_oe,
    input wire logic [6:0]  charge_pump_current,
    input wire logic        phi_r,
    input wire logic        phi_v,
    input wire logic        lock_indicator
);
    logic [2:0] mode_r;
    logic [7:0] cfg_r;
    logic       wr_ok;
    logic [6:0] code;
    logic [6:0] cur_exp;

    assign wr_ok   = psel && penable && pready && pwrite && pstrb[0];
    assign code    = {5'h00, cfg_r[3:2]};
    assign cur_exp = cfg_r[1] ? 7'h19 * (code + 7'h01) : 7'h46 + 7'h0A * code;

    // Shadow copies of mode and config, taken at the write edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= 3'h6;
            cfg_r  <= 8'h00;
        end
        else if (wr_ok && paddr == 12'h000)
            mode_r <= pwdata[2:0];
        else if (wr_ok && paddr == 12'h004)
            cfg_r <= {pwdata[7:1], 1'b0};
    end

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    lock_and_a: assert property (lock_indicator |-> phi_r && phi_v)
        else $error("lock high with a pulse output low");
    pair_once_a: assert property (!phi_r && !phi_v |=> phi_r && phi_v)
        else $error("pulse pair low longer than one cycle");
    phi_cause_a: assert property ($fell(phi_r) || $fell(phi_v) |->
        ($past(divided_reference_pulse) && !$past(divided_reference_pulse, 2)) ||
        ($past(divided_vco_pulse) && !$past(divided_vco_pulse, 2)))
        else $error("pulse output fell without an input edge");
    lock_off_a: assert property (!cfg_r[5] |-> !lock_indicator)
        else $error("lock high while disabled");
    save_quiet_a: assert property (cfg_r[4] |->
        !charge_pump_oe && phi_r && phi_v)
        else $error("detector active in power save");
    select_pair_a: assert property (cfg_r[6] |-> phi_r && phi_v)
        else $error("pulse pair active while pump selected");
    pump_off_a: assert property (!cfg_r[6] |-> !charge_pump_oe)
        else $error("pump driving while deselected");
    pump_current_a: assert property (charge_pump_current == cur_exp)
        else $error("pump current wrong");
    xtal_off_a: assert property (mode_r == 3'h0 |-> !osc_run)
        else $error("oscillator running in mode zero");
    xtal_run_a: assert property (mode_r == 3'h1 |-> osc_run)
        else $error("oscillator stopped in crystal mode");
    div1_pass_a: assert property (mode_r == 3'h3 |->
        divided_osc_output == $past(osc_input))
        else $error("one to one output wrong");
    out_off_a: assert property (mode_r == 3'h2 |-> !divided_osc_output)
        else $error("output active in mode two");
endmodule : pll_ref_props

bind pll_ref_and_phase_detect pll_ref_props props_i
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .osc_input, .divided_reference_pulse, .divided_vco_pulse, .divided_osc_output,
    .osc_run, .charge_pump_oe, .charge_pump_current, .phi_r, .phi_v, .lock_indicator
);
`default_nettype wire

// [sim/pll_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_far_side
(
    input  wire logic       pclk,
    input  wire logic [3:0] osc_half,
    output logic            osc_input,
    output logic            vco_input
);
    logic [3:0] cnt_r;

    initial
    begin
        cnt_r     = 4'h0;
        osc_input = 1'b0;
        vco_input = 1'b0;
    end

    // Free-running reference and VCO, independent of the device mode
    always @(posedge pclk)
    begin
        vco_input <= !vco_input;
        cnt_r     <= (cnt_r + 4'h1 >= osc_half) ? 4'h0 : cnt_r + 4'h1;
        if (cnt_r + 4'h1 >= osc_half)
            osc_input <= !osc_input;
    end
endmodule : pll_far_side
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [2:0] mode;
        logic [7:0] cfg;
        logic [6:0] cur;
        logic       run;
        logic       cnt;
    } row_t;

    logic        pclk, presetn, psel, penable, pwrite, modulus_select;
    logic        divided_reference_pulse, divided_vco_pulse, e_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v_v;
    logic [3:0]  pstrb, osc_half;
    logic        pready, pslverr, osc_input, vco_input, divided_osc_output, osc_run;
    logic        ref_count_enable, charge_pump_output, charge_pump_oe, phi_r, phi_v;
    logic        lock_indicator, prescaler_output, osc_q, div_q, vco_q, pre_q;
    logic [6:0]  charge_pump_current;
    int          n_fail, checked, rises, vrises;
    row_t        rows [8] = '{'{3'h1, 8'h00, 7'h46, 1'b1, 1'b1},
                              '{3'h1, 8'h14, 7'h50, 1'b1, 1'b0},
                              '{3'h0, 8'h08, 7'h5A, 1'b0, 1'b0},
                              '{3'h0, 8'h1C, 7'h64, 1'b0, 1'b0},
                              '{3'h7, 8'h02, 7'h19, 1'b0, 1'b1},
                              '{3'h7, 8'h06, 7'h32, 1'b0, 1'b1},
                              '{3'h2, 8'h0A, 7'h4B, 1'b0, 1'b1},
                              '{3'h2, 8'h0E, 7'h64, 1'b0, 1'b1}};

    pll_ref_and_phase_detect dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .osc_input, .divided_reference_pulse, .divided_vco_pulse,
        .vco_input, .modulus_select, .divided_osc_output, .osc_run, .ref_count_enable,
        .charge_pump_output, .charge_pump_oe, .charge_pump_current, .phi_r, .phi_v,
        .lock_indicator, .prescaler_output
    );

    pll_far_side far (.pclk, .osc_half, .osc_input, .vco_input);

    always @(posedge pclk)
    begin
        osc_q  <= osc_input;
        div_q  <= divided_osc_output;
        vco_q  <= vco_input;
        pre_q  <= prescaler_output;
        rises  <= rises + int'(osc_input && !osc_q);
        vrises <= vrises + int'(vco_input && !vco_q);
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rdat, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        e    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            n_fail++;
    endtask : apb

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, v_v, e_v);
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000, 4'h0, v_v, e_v);
        check(nm, v_v, exp);
    endtask : rd_reg

    // Counts input rises between two output rises
    task automatic gap(input logic pre, input int exp, input string nm);
        int r[3];
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while ((pre ? prescaler_output && !pre_q : divided_osc_output && !div_q) !== 1'b1
                   && n < 2000);
            r[k] = pre ? vrises : rises;
        end
        check(nm, r[2] - r[1], exp);
    endtask : gap

    task automatic pfd(input logic [7:0] cfg, input logic vf);
        logic act;
        logic side;
        act  = !cfg[4];
        side = vf ^ cfg[7];
        wr_reg(12'h004, {24'h00_0000, cfg});
        repeat (3) @(posedge pclk);
        divided_vco_pulse       <= vf;
        divided_reference_pulse <= !vf;
        @(posedge pclk);
        #1;
        if (cfg[6])
        begin
            check("pump oe", charge_pump_oe, act);
            if (act)
                check("pump sense", charge_pump_output, !side);
        end
        else
        begin
            check("phi v", phi_v, !(act && side));
            check("phi r", phi_r, !(act && !side));
        end
        check("lock lead", lock_indicator, cfg[5] && !(act && !cfg[6]));
        @(posedge pclk);
        divided_vco_pulse       <= 1'b1;
        divided_reference_pulse <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        check("lock idle", lock_indicator, cfg[5]);
        @(posedge pclk);
        divided_vco_pulse       <= 1'b0;
        divided_reference_pulse <= 1'b0;
    endtask : pfd

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        divided_reference_pulse = 1'b0;
        divided_vco_pulse = 1'b0;
        modulus_select = 1'b0;
        osc_half = 4'hD;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("lock at reset", lock_indicator, 1'b0);
        check("pump at reset", charge_pump_oe, 1'b0);
        gap(1'b0, 8, "reset ratio");
        rd_reg(12'h000, 32'h0000_0006, "mode reset");
        rd_reg(12'h004, 32'h0000_0000, "config reset");
        wr_reg(12'h004, 32'h0000_00FF);
        apb(1'b1, 12'h004, 32'h0000_0000, 4'h0, v_v, e_v);
        rd_reg(12'h004, 32'h0000_00FE, "config bits");
        apb(1'b0, 12'h00C, 32'h0000_0000, 4'h0, v_v, e_v);
        check("unmapped", e_v, 1'b1);
        foreach (rows[i])
        begin
            wr_reg(12'h000, {29'h0000_0000, rows[i].mode});
            wr_reg(12'h004, {24'h00_0000, rows[i].cfg});
            repeat (3) @(posedge pclk);
            #1;
            check("current", charge_pump_current, rows[i].cur);
            check("osc run", osc_run, rows[i].run);
            check("ref count", ref_count_enable, rows[i].cnt);
        end
        // Status in mode two, config 0E: prescaler bit left out
        apb(1'b0, 12'h008, 32'h0000_0000, 4'h0, v_v, e_v);
        check("status", v_v & 32'hFFFD_FFFF, 32'h0000_64C2);
        for (int m = 3; m < 8; m++)
        begin
            wr_reg(12'h000, m);
            gap(1'b0, 1 << (m - 3), "ref ratio");
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            modulus_select <= k[0];
            gap(1'b1, 65 - k, "modulus");
        end
        for (int i = 0; i < 8; i++)
            pfd({i[0], i[1], 6'h20}, i[2]);
        pfd(8'h70, 1'b1);
        pfd(8'h30, 1'b0);
        // Reset in mid-run brings mode and config back to defaults
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("lock after reset", lock_indicator, 1'b0);
        rd_reg(12'h000, 32'h0000_0006, "mode after reset");
        rd_reg(12'h004, 32'h0000_0000, "config after reset");
        complete_run();
    end
endmodule : tb
`default_nettype wire
